// File: src/fdc_read_pkg.sv
package fdc_read_pkg;
// Contract
// - multi-track clear stops at last sector of the current side; set continues from side 0 onto side 1
// - drive-select bits pick logical drive 0..3, honouring four-drive and 2/0 swap
// - side bit of second byte drives head side output active for side 1
// - second byte bit 7 enables implied seek; software reset clears it
// - nine command bytes in fixed order from opcode to obsolete length
// - ninth command byte is ignored whatever its value
// - implied seek runs seek to target track then waits head settle time
// - compare track, head, sector, size of each address field; retry until match
// - host command write during execution aborts into the result phase
// - two index pulses, track differs: wrong-track or bad-track status bit
// - two index pulses: other mismatch sets missing data, no mark sets missing mark
// - address field CRC error sets CRC bit in second status and ends
// - no data mark within the wait time sets missing mark and ends
// - read data: deleted sector sets control mark and stops, or skipped
// - transfer sector bytes, then check the data field CRC
// - transfer end strobe stops reading with normal termination code
// - last sector equal to end-of-track number sets end bit, abnormal code
// - host too slow for a byte sets overrun bit, abnormal code
// - data CRC error sets CRC bits in second and third status, abnormal
// - interrupt line rises at result phase; results name the sector in work
// - deleted variant behaves like read data except control mark and skipping
// - normal end reports next sector; wraps to sector 1, next track or side
// - deleted variant: normal sector marked and stops, or skipped when skipping
// - wait per-drive delay before processing after the last command byte
// - opcode bit 5 selects skipping, bit 6 selects double density
  localparam logic [4:0] OP_READ_DATA     = 5'h06;
  localparam logic [4:0] OP_READ_DELETED  = 5'h0C;
  localparam int         OPC_MULTI_TRACK  = 7;
  localparam int         OPC_DOUBLE_DENS  = 6;
  localparam int         OPC_PASS_DELETED = 5;
  localparam int         SEL_IMPLIED_SEEK = 7;
  localparam int         SEL_SIDE         = 2;
  localparam int         ST1_END_TRACK    = 7;
  localparam int         ST1_CRC          = 5;
  localparam int         ST1_OVERRUN      = 4;
  localparam int         ST1_MISS_DATA    = 2;
  localparam int         ST1_MISS_MARK    = 0;
  localparam int         ST2_CTRL_MARK    = 6;
  localparam int         ST2_DATA_CRC     = 5;
  localparam int         ST2_WRONG_TRACK  = 4;
  localparam int         ST2_BAD_TRACK    = 1;
  localparam logic [1:0] TERM_NORMAL      = 2'h0;
  localparam logic [1:0] TERM_ABNORMAL    = 2'h1;
  localparam logic [7:0] BAD_TRACK_ID     = 8'hFF;
  localparam int         CMD_BYTES        = 9;
  localparam int         RES_BYTES        = 7;
  localparam int         INDEX_LIMIT      = 2;
  localparam int         SECTOR_BASE      = 128;
  localparam int         HOST_FIFO_DEPTH  = 8;
  localparam int         CLK_MHZ          = 250;
  localparam int         DATA_WAIT_US     = 2000;
  localparam int         DATA_WAIT_CYCLES = DATA_WAIT_US * CLK_MHZ;

  typedef struct packed {
    logic [7:0] track;
    logic [7:0] head;
    logic [7:0] sector;
    logic [7:0] size;
  } sector_id_t;

  typedef enum logic [3:0] {
    S_IDLE, S_DELAY, S_SEEK, S_SETTLE, S_SEARCH, S_DATA_WAIT, S_XFER, S_CRC, S_RESULT
  } seq_state_t;
endpackage : fdc_read_pkg

// File: src/floppy_read_data_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
// power-of-two depth only: pointers wrap by overflow
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr;
  logic [AW-1:0]    rptr;
  logic [AW:0]      fill;
  logic [AW:0]      next_fill;
  logic             push;
  logic             pop;

  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign next_fill = fill + (AW+1)'(push) - (AW+1)'(pop);
  assign out_data  = mem[rptr];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wptr      <= '0;
      rptr      <= '0;
      fill      <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else if (flush) begin
      wptr      <= '0;
      rptr      <= '0;
      fill      <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      wptr      <= wptr + AW'(push);
      rptr      <= rptr + AW'(pop);
      fill      <= next_fill;
      in_ready  <= next_fill != (AW+1)'(DEPTH);
      out_valid <= next_fill != '0;
    end
  end
endmodule : byte_fifo

module floppy_read_data_sequencer
  import fdc_read_pkg::*;
#(
  parameter int DATA_WAIT  = DATA_WAIT_CYCLES,
  parameter int FIFO_DEPTH = HOST_FIFO_DEPTH
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        soft_reset,
  input  wire logic        cmd_write,
  input  wire logic [7:0]  cmd_byte,
  output logic             res_valid,
  output logic [7:0]       res_byte,
  input  wire logic        res_read,
  output logic             rd_valid,
  output logic [7:0]       rd_byte,
  input  wire logic        rd_ready,
  output logic             busy,
  output logic             host_interrupt_line,
  input  wire logic        transfer_end_strobe,
  input  wire logic        index_pulse,
  input  wire logic        four_drives,
  input  wire logic        swap_drives,
  input  wire logic [23:0] dbp_cycles,
  input  wire logic [23:0] settle_cycles,
  output logic [3:0]       drive_select,
  output logic             head_side_output,
  output logic             double_density_select,
  output logic             seek_req,
  output logic [7:0]       seek_track,
  input  wire logic        seek_done,
  output logic             sep_enable,
  input  wire logic        sep_id_valid,
  input  wire sector_id_t  sep_id,
  input  wire logic        sep_id_crc_bad,
  input  wire logic        sep_data_mark,
  input  wire logic        sep_data_deleted,
  input  wire logic        sep_byte_valid,
  input  wire logic [7:0]  sep_byte,
  input  wire logic        sep_crc_done,
  input  wire logic        sep_crc_bad
);
  seq_state_t state;
  seq_state_t next_state;
  sector_id_t want;
  logic [3:0]  cmd_idx;
  logic [2:0]  res_idx;
  logic [23:0] cnt;
  logic [1:0]  idx_cnt;
  logic [7:0]  last_sector_number;
  logic [1:0]  logical_drive_choice;
  logic [1:0]  termination_code;
  logic [7:0]  result_status_second;
  logic [7:0]  result_status_third;
  logic        multi_track_enable;
  logic        pass_over_deleted;
  logic        implied_seek_enable;
  logic        side_choice_bit;
  logic        read_deleted;
  logic        tc_s1, tc_s2, tc_hold;
  logic        idx_s1, idx_s2, idx_s3;
  logic        cm_stop, saw_id, trk_diff, trk_bad, oth_diff, res_pending;
  logic        fifo_ready;
  logic        exec, take_cmd, last_byte, abort, idx_edge;
  logic        id_crc_err, id_hit, index_fail, mark_seen, mark_ctrl, skip_sector;
  logic        data_timeout, overrun, crc_done, sector_ok, at_eot, to_side1, more;
  logic        end_now;
  logic [15:0] sector_bytes;

  function automatic logic [3:0] drive_map(input logic [1:0] ds, input logic four,
                                           input logic swap);
    case (ds)
      2'h0:    drive_map = swap ? 4'h4 : 4'h1;
      2'h1:    drive_map = 4'h2;
      2'h2:    drive_map = (four | swap) ? (swap ? 4'h1 : 4'h4) : 4'h0;
      default: drive_map = four ? 4'h8 : 4'h0;
    endcase
  endfunction : drive_map

  function automatic logic [7:0] res_pick(input logic [2:0] i, input logic [7:0] s0,
                                          input logic [7:0] s1, input logic [7:0] s2,
                                          input sector_id_t id);
    case (i)
      3'h0:    res_pick = s0;
      3'h1:    res_pick = s1;
      3'h2:    res_pick = s2;
      3'h3:    res_pick = id.track;
      3'h4:    res_pick = id.head;
      3'h5:    res_pick = id.sector;
      default: res_pick = id.size;
    endcase
  endfunction : res_pick

  // pins from outside the clock domain
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tc_s1  <= 1'b0;
      tc_s2  <= 1'b0;
      idx_s1 <= 1'b0;
      idx_s2 <= 1'b0;
      idx_s3 <= 1'b0;
    end else begin
      tc_s1  <= transfer_end_strobe;
      tc_s2  <= tc_s1;
      idx_s1 <= index_pulse;
      idx_s2 <= idx_s1;
      idx_s3 <= idx_s2;
    end
  end

  assign idx_edge     = idx_s2 & ~idx_s3;
  assign exec         = state inside {S_DELAY, S_SEEK, S_SETTLE, S_SEARCH, S_DATA_WAIT,
                                      S_XFER, S_CRC};
  assign sector_bytes = 16'(SECTOR_BASE) << want.size[2:0];
  assign take_cmd     = cmd_write & (state == S_IDLE) & ~soft_reset &
                        ((cmd_idx != 4'h0) | (cmd_byte[4:0] == OP_READ_DATA) |
                         (cmd_byte[4:0] == OP_READ_DELETED));
  assign last_byte    = take_cmd & (cmd_idx == 4'(CMD_BYTES - 1));
  assign abort        = cmd_write & exec;
  assign id_crc_err   = (state == S_SEARCH) & sep_id_valid & sep_id_crc_bad;
  assign id_hit       = (state == S_SEARCH) & sep_id_valid & ~sep_id_crc_bad &
                        (sep_id == want);
  assign index_fail   = (state == S_SEARCH) & idx_edge &
                        (idx_cnt == 2'(INDEX_LIMIT - 1)) & ~id_hit;
  assign mark_seen    = (state == S_DATA_WAIT) & sep_data_mark;
  // wrong mark type for the command: deleted for read data, normal for read deleted
  assign mark_ctrl    = sep_data_deleted ^ read_deleted;
  assign skip_sector  = mark_seen & mark_ctrl & pass_over_deleted;
  assign data_timeout = (state == S_DATA_WAIT) & ~sep_data_mark &
                        (cnt == 24'(DATA_WAIT - 1));
  assign overrun      = (state == S_XFER) & sep_byte_valid & ~tc_hold & ~fifo_ready;
  assign crc_done     = (state == S_CRC) & sep_crc_done;
  assign sector_ok    = (crc_done & ~sep_crc_bad) | skip_sector;
  assign at_eot       = want.sector == last_sector_number;
  assign to_side1     = at_eot & multi_track_enable & ~head_side_output;
  assign more         = sector_ok & ~tc_hold & ~cm_stop & (~at_eot | to_side1);
  assign end_now      = abort | id_crc_err | index_fail | data_timeout | overrun |
                        (crc_done & sep_crc_bad) | (sector_ok & ~more);

  always_comb begin
    next_state = state;
    case (state)
      S_IDLE:      if (last_byte) next_state = S_DELAY;
      S_DELAY:     if (cnt >= dbp_cycles) begin
        next_state = implied_seek_enable ? S_SEEK : S_SEARCH;
      end
      S_SEEK:      if (seek_done) next_state = S_SETTLE;
      S_SETTLE:    if (cnt >= settle_cycles) next_state = S_SEARCH;
      S_SEARCH:    if (id_hit) next_state = S_DATA_WAIT;
      S_DATA_WAIT: if (skip_sector) next_state = S_SEARCH;
                   else if (mark_seen) next_state = S_XFER;
      S_XFER:      if (sep_byte_valid && cnt == 24'(sector_bytes - 16'h0001)) begin
        next_state = S_CRC;
      end
      S_CRC:       if (more) next_state = S_SEARCH;
      S_RESULT:    if (res_read && res_valid && res_idx == 3'(RES_BYTES - 1)) begin
        next_state = S_IDLE;
      end
      default:     next_state = S_IDLE;
    endcase
    if (end_now) next_state = S_RESULT;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state      <= S_IDLE;
      cnt        <= '0;
      idx_cnt    <= '0;
      sep_enable <= 1'b0;
      seek_req   <= 1'b0;
    end else if (soft_reset) begin
      state      <= S_IDLE;
      cnt        <= '0;
      idx_cnt    <= '0;
      sep_enable <= 1'b0;
      seek_req   <= 1'b0;
    end else begin
      state      <= next_state;
      sep_enable <= next_state inside {S_SEARCH, S_DATA_WAIT, S_XFER, S_CRC};
      seek_req   <= next_state == S_SEEK;
      if (next_state != state || more) begin
        cnt <= '0;
      end else if (state != S_XFER || sep_byte_valid) begin
        cnt <= cnt + 24'h00_0001;
      end
      // the two-pulse window restarts with every new sector search
      if (next_state == S_SEARCH && (state != S_SEARCH || more)) begin
        idx_cnt <= '0;
      end else if (state == S_SEARCH && idx_edge) begin
        idx_cnt <= idx_cnt + 2'h1;
      end
    end
  end

  // command capture and the sector position that advances as sectors finish
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_idx               <= '0;
      want                  <= '0;
      last_sector_number    <= '0;
      multi_track_enable    <= 1'b0;
      double_density_select <= 1'b0;
      pass_over_deleted     <= 1'b0;
      read_deleted          <= 1'b0;
      implied_seek_enable   <= 1'b0;
      side_choice_bit       <= 1'b0;
      logical_drive_choice  <= '0;
      head_side_output      <= 1'b0;
      drive_select          <= 4'h1;
      seek_track            <= '0;
    end else if (soft_reset) begin
      cmd_idx             <= '0;
      implied_seek_enable <= 1'b0;
    end else begin
      seek_track <= want.track;
      if (take_cmd) begin
        cmd_idx <= last_byte ? 4'h0 : cmd_idx + 4'h1;
        case (cmd_idx)
          4'h0: begin
            multi_track_enable    <= cmd_byte[OPC_MULTI_TRACK];
            double_density_select <= cmd_byte[OPC_DOUBLE_DENS];
            pass_over_deleted     <= cmd_byte[OPC_PASS_DELETED];
            read_deleted          <= cmd_byte[4:0] == OP_READ_DELETED;
          end
          4'h1: begin
            implied_seek_enable  <= cmd_byte[SEL_IMPLIED_SEEK];
            side_choice_bit      <= cmd_byte[SEL_SIDE];
            head_side_output     <= cmd_byte[SEL_SIDE];
            logical_drive_choice <= cmd_byte[1:0];
            drive_select         <= drive_map(cmd_byte[1:0], four_drives, swap_drives);
          end
          4'h2: want.track  <= cmd_byte;
          4'h3: want.head   <= cmd_byte;
          4'h4: want.sector <= cmd_byte;
          4'h5: want.size   <= cmd_byte;
          4'h6: last_sector_number <= cmd_byte;
          default: ; // gap length and obsolete length are not used
        endcase
      end else if (sector_ok) begin
        if (!at_eot) begin
          want.sector <= want.sector + 8'h01;
        end else if (to_side1) begin
          want.sector      <= 8'h01;
          want.head        <= 8'h01;
          head_side_output <= 1'b1;
        end else begin
          want.sector <= 8'h01;
          want.track  <= want.track + 8'h01;
          if (multi_track_enable) begin
            want.head <= 8'h00;
          end
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      termination_code     <= TERM_NORMAL;
      result_status_second <= '0;
      result_status_third  <= '0;
      tc_hold              <= 1'b0;
      cm_stop              <= 1'b0;
      saw_id               <= 1'b0;
      trk_diff             <= 1'b0;
      trk_bad              <= 1'b0;
      oth_diff             <= 1'b0;
    end else if (soft_reset || last_byte) begin
      termination_code     <= TERM_NORMAL;
      result_status_second <= '0;
      result_status_third  <= '0;
      tc_hold              <= 1'b0;
      cm_stop              <= 1'b0;
      saw_id               <= 1'b0;
      trk_diff             <= 1'b0;
      trk_bad              <= 1'b0;
      oth_diff             <= 1'b0;
    end else begin
      if (exec && tc_s2) tc_hold <= 1'b1;
      if (state == S_SEARCH && sep_id_valid && !sep_id_crc_bad) begin
        saw_id   <= 1'b1;
        trk_diff <= sep_id.track != want.track;
        trk_bad  <= sep_id.track == BAD_TRACK_ID;
        oth_diff <= sep_id[23:0] != want[23:0];
      end
      if (mark_seen && mark_ctrl) begin
        result_status_third[ST2_CTRL_MARK] <= 1'b1;
        if (!pass_over_deleted) cm_stop <= 1'b1;
      end
      if (index_fail) begin
        if (!saw_id) result_status_second[ST1_MISS_MARK] <= 1'b1;
        if (saw_id && oth_diff) result_status_second[ST1_MISS_DATA] <= 1'b1;
        if (saw_id && trk_diff && trk_bad) result_status_third[ST2_BAD_TRACK] <= 1'b1;
        if (saw_id && trk_diff && !trk_bad) result_status_third[ST2_WRONG_TRACK] <= 1'b1;
      end
      if (id_crc_err) result_status_second[ST1_CRC] <= 1'b1;
      if (data_timeout) result_status_second[ST1_MISS_MARK] <= 1'b1;
      if (overrun) result_status_second[ST1_OVERRUN] <= 1'b1;
      if (crc_done && sep_crc_bad) begin
        result_status_second[ST1_CRC] <= 1'b1;
        result_status_third[ST2_DATA_CRC] <= 1'b1;
      end
      if (sector_ok && !more && !tc_hold && !cm_stop) begin
        result_status_second[ST1_END_TRACK] <= 1'b1;
      end
      // end-of-track wins no abnormal code once the strobe has stopped the read
      if (end_now) begin
        termination_code <= (sector_ok && (tc_hold || cm_stop)) ? TERM_NORMAL
                                                                 : TERM_ABNORMAL;
      end
    end
  end

  // result bytes load one cycle after the end so status and position are settled
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      res_pending         <= 1'b0;
      res_valid           <= 1'b0;
      res_byte            <= '0;
      res_idx             <= '0;
      busy                <= 1'b0;
      host_interrupt_line <= 1'b0;
    end else if (soft_reset) begin
      res_pending         <= 1'b0;
      res_valid           <= 1'b0;
      res_byte            <= '0;
      res_idx             <= '0;
      busy                <= 1'b0;
      host_interrupt_line <= 1'b0;
    end else begin
      res_pending <= end_now;
      if (take_cmd) busy <= 1'b1;
      if (res_pending) begin
        res_idx             <= '0;
        res_valid           <= 1'b1;
        host_interrupt_line <= 1'b1;
        res_byte            <= res_pick(3'h0, {termination_code, 3'h0, head_side_output,
                                        logical_drive_choice}, result_status_second,
                                        result_status_third, want);
      end else if (res_read && res_valid) begin
        host_interrupt_line <= 1'b0;
        if (res_idx == 3'(RES_BYTES - 1)) begin
          res_valid <= 1'b0;
          busy      <= 1'b0;
        end else begin
          res_idx  <= res_idx + 3'h1;
          res_byte <= res_pick(res_idx + 3'h1, 8'h00, result_status_second,
                               result_status_third, want);
        end
      end
    end
  end

  // a full buffer back-pressures the disk stream, which can only show as overrun
  byte_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_data_fifo (
    .clk       (clk),
    .arst_n    (arst_n),
    .flush     (soft_reset),
    .in_valid  ((state == S_XFER) & sep_byte_valid & ~tc_hold),
    .in_ready  (fifo_ready),
    .in_data   (sep_byte),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_byte)
  );
endmodule : floppy_read_data_sequencer
`default_nettype wire

// File: test/fdc_drive_model.sv
`timescale 1ns/1ps
`default_nettype none
module fdc_drive_model
  import fdc_read_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       disk,
  input  wire sector_id_t id_in,
  input  wire logic       del_in,
  input  wire logic       crc_bad_in,
  input  wire logic       sep_enable,
  input  wire logic       seek_req,
  output logic            seek_done,
  output logic            sep_id_valid,
  output var sector_id_t  sep_id,
  output logic            sep_data_mark,
  output logic            sep_data_deleted,
  output logic            sep_byte_valid,
  output logic [7:0]      sep_byte,
  output logic            sep_crc_done,
  output logic            sep_crc_bad
);
  int n;
  always @(posedge clk) seek_done <= seek_req & ~seek_done;
  initial begin
    {sep_id_valid, sep_data_mark, sep_data_deleted} = '0;
    {sep_byte_valid, sep_crc_done, sep_crc_bad} = '0;
    sep_id = '0;
    sep_byte = 8'h00;
    forever begin
      // no disk: nothing ever arrives, only a host abort or two index pulses end the read
      @(posedge clk iff (sep_enable === 1'b1 && disk));
      repeat (3) @(posedge clk);
      sep_id <= id_in;
      sep_id_valid <= 1'b1;
      @(posedge clk);
      sep_id_valid <= 1'b0;
      sep_id <= ~id_in;
      repeat (3) @(posedge clk);
      sep_data_mark <= 1'b1;
      sep_data_deleted <= del_in;
      @(posedge clk);
      sep_data_mark <= 1'b0;
      for (n = 0; n < (SECTOR_BASE << id_in.size[2:0]); n++) begin
        sep_byte_valid <= 1'b1;
        sep_byte <= n[7:0];
        @(posedge clk);
        sep_byte_valid <= 1'b0;
        sep_byte <= ~n[7:0];
        @(posedge clk);
      end
      sep_crc_done <= 1'b1;
      sep_crc_bad <= crc_bad_in;
      @(posedge clk);
      sep_crc_done <= 1'b0;
      wait (sep_enable !== 1'b1);
    end
  end
endmodule : fdc_drive_model
`default_nettype wire

// File: test/floppy_read_data_sequencer_sva.sv
`timescale 1ns/1ps
`default_nettype none
module floppy_read_data_sequencer_sva (
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic       soft_reset,
  input wire logic       res_valid,
  input wire logic [7:0] res_byte,
  input wire logic       res_read,
  input wire logic       busy,
  input wire logic       host_interrupt_line,
  input wire logic [3:0] drive_select,
  input wire logic       sep_enable,
  input wire logic       seek_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_irq_with_result: assert property ($rose(host_interrupt_line) |-> res_valid)
    else $error("interrupt rose without a result byte");
  a_result_raises_irq: assert property ($rose(res_valid) |-> host_interrupt_line)
    else $error("result phase began without interrupt");
  a_irq_read_clear: assert property (host_interrupt_line && res_read |=> !host_interrupt_line)
    else $error("interrupt not cleared by result read");
  a_busy_in_result: assert property (res_valid |-> busy)
    else $error("result pending while not busy");
  a_busy_ends_read: assert property ($fell(busy) && !$past(soft_reset) |-> $past(res_read))
    else $error("busy dropped without a result read");
  a_result_holds: assert property (res_valid && !res_read && !soft_reset |=>
    res_valid && $stable(res_byte)) else $error("result byte changed unread");
  a_quiet_in_result: assert property (res_valid |-> !sep_enable && !seek_req)
    else $error("drive activity during result phase");
  a_one_drive: assert property ($onehot0(drive_select))
    else $error("more than one drive selected");
endmodule : floppy_read_data_sequencer_sva
bind floppy_read_data_sequencer floppy_read_data_sequencer_sva u_sva (
  .clk(clk), .arst_n(arst_n), .soft_reset(soft_reset), .res_valid(res_valid),
  .res_byte(res_byte), .res_read(res_read), .busy(busy),
  .host_interrupt_line(host_interrupt_line), .drive_select(drive_select),
  .sep_enable(sep_enable), .seek_req(seek_req));
`default_nettype wire

// File: test/floppy_read_data_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module floppy_read_data_sequencer_tb;
  import fdc_read_pkg::*;
  logic clk = 0, arst_n = 0, soft_reset = 0, cmd_write = 0, res_read = 0, rd_ready = 1;
  logic disk = 1, del = 0, crc_bad = 0, res_valid, rd_valid, busy, irq, side, dd;
  logic seek_req, seek_done, sep_en, idv, dm, ddel, bv, cd, cbad, tc = 0, idx = 0;
  logic [7:0] cmd_byte = 8'h00, res_byte, rd_byte, seek_track, sbyte;
  logic [3:0] drive_select;
  sector_id_t sid, id = '0;
  int n_mismatch = 0, check_count = 0, n_rd = 0;
  floppy_read_data_sequencer #(.DATA_WAIT(64)) uut (.clk(clk), .arst_n(arst_n),
    .soft_reset(soft_reset), .cmd_write(cmd_write), .cmd_byte(cmd_byte), .res_valid(res_valid),
    .res_byte(res_byte), .res_read(res_read), .rd_valid(rd_valid), .rd_byte(rd_byte),
    .rd_ready(rd_ready), .busy(busy), .host_interrupt_line(irq), .transfer_end_strobe(tc),
    .index_pulse(idx), .four_drives(1'b0), .swap_drives(1'b0), .dbp_cycles(24'h00_000A),
    .settle_cycles(24'h00_000A), .drive_select(drive_select), .head_side_output(side),
    .double_density_select(dd), .seek_req(seek_req), .seek_track(seek_track),
    .seek_done(seek_done), .sep_enable(sep_en), .sep_id_valid(idv), .sep_id(sid),
    .sep_id_crc_bad(1'b0), .sep_data_mark(dm), .sep_data_deleted(ddel), .sep_byte_valid(bv),
    .sep_byte(sbyte), .sep_crc_done(cd), .sep_crc_bad(cbad));
  fdc_drive_model far (.clk(clk), .disk(disk), .id_in(id), .del_in(del), .crc_bad_in(crc_bad),
    .sep_enable(sep_en), .seek_req(seek_req), .seek_done(seek_done), .sep_id_valid(idv),
    .sep_id(sid), .sep_data_mark(dm), .sep_data_deleted(ddel), .sep_byte_valid(bv),
    .sep_byte(sbyte), .sep_crc_done(cd), .sep_crc_bad(cbad));
  initial forever #2 clk = ~clk;
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  task automatic send(input logic [7:0] b [9]);
    n_rd = 0;
    foreach (b[i]) begin
      @(negedge clk);
      cmd_write = 1;
      cmd_byte = b[i];
    end
    @(negedge clk);
    cmd_write = 0;
  endtask : send
  task automatic results(input string nm, input logic [7:0] e [7]);
    foreach (e[i]) begin
      repeat (3000) if (res_valid !== 1'b1) @(negedge clk);
      if (i == 0) chk("interrupt", {7'h00, irq}, 8'h01);
      chk("result", res_byte, e[i]);
      res_read = 1;
      @(negedge clk);
      res_read = 0;
      @(negedge clk);
    end
    chk("busy", {7'h00, busy}, 8'h00);
    $display("test %s done", nm);
  endtask : results
  always @(posedge clk) if (rd_valid === 1'b1 && rd_ready) begin
    chk("read byte", rd_byte, n_rd[7:0]);
    n_rd++;
  end
  initial begin
    repeat (4) @(negedge clk);
    arst_n = 1;
    @(negedge clk);
    soft_reset = 1;
    @(negedge clk);
    soft_reset = 0;
    id = '{8'h03, 8'h01, 8'h01, 8'h00};
    send('{8'h06, 8'h85, 8'h03, 8'h01, 8'h01, 8'h00, 8'h01, 8'h1B, 8'hFF});
    repeat (3000) if (sep_en !== 1'b1) @(negedge clk);
    chk("seek track", seek_track, 8'h03);
    chk("drive", {4'h0, drive_select}, 8'h02);
    chk("side", {7'h00, side}, 8'h01);
    results("last sector", '{8'h45, 8'h80, 8'h00, 8'h04, 8'h01, 8'h01, 8'h00});
    chk("byte count", n_rd[7:0], 8'h80);
    id = '{8'h03, 8'h00, 8'h02, 8'h00};
    for (int k = 0; k < 2; k++) begin
      del = (k == 0);
      send('{(k == 0) ? 8'h46 : 8'h4C, 8'h00, 8'h03, 8'h00, 8'h02, 8'h00, 8'h05, 8'h1B, 8'hFF});
      repeat (3000) if (sep_en !== 1'b1) @(negedge clk);
      chk("density", {7'h00, dd}, 8'h01);
      results("control mark", '{8'h00, 8'h00, 8'h40, 8'h03, 8'h00, 8'h03, 8'h00});
    end
    del = 0;
    crc_bad = 1;
    send('{8'h06, 8'h00, 8'h03, 8'h00, 8'h02, 8'h00, 8'h05, 8'h1B, 8'hFF});
    results("data crc", '{8'h40, 8'h20, 8'h20, 8'h03, 8'h00, 8'h02, 8'h00});
    crc_bad = 0;
    disk = 0;
    send('{8'h06, 8'h00, 8'h03, 8'h00, 8'h02, 8'h00, 8'h05, 8'h1B, 8'hFF});
    repeat (50) @(negedge clk);
    cmd_write = 1;
    @(negedge clk);
    cmd_write = 0;
    results("abort", '{8'h40, 8'h00, 8'h00, 8'h03, 8'h00, 8'h02, 8'h00});
    send('{8'h06, 8'h00, 8'h03, 8'h00, 8'h02, 8'h00, 8'h05, 8'h1B, 8'hFF});
    repeat (30) @(negedge clk);
    repeat (4) @(negedge clk) idx = ~idx;
    results("index", '{8'h40, 8'h01, 8'h00, 8'h03, 8'h00, 8'h02, 8'h00});
    disk = 1;
    tc = 1;
    send('{8'h06, 8'h00, 8'h03, 8'h00, 8'h02, 8'h00, 8'h05, 8'h1B, 8'hFF});
    results("terminal count", '{8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'h03, 8'h00});
    tc = 0;
    rd_ready = 0;
    send('{8'h06, 8'h00, 8'h03, 8'h00, 8'h02, 8'h00, 8'h05, 8'h1B, 8'hFF});
    results("overrun", '{8'h40, 8'h10, 8'h00, 8'h03, 8'h00, 8'h02, 8'h00});
    rd_ready = 1;
    repeat (12) @(negedge clk);
    chk("drained", n_rd[7:0], 8'h08);
    test_done();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    test_done();
  end
endmodule : floppy_read_data_sequencer_tb
`default_nettype wire
